// ==== logic/mmc_config_regs.sv ====
/*
 * Five 8-bit mode configuration registers of the metering core, written
 * and read over the serial register port, plus qualified mode outputs.
 * Assumes the port logic, the compensation group select and the capture
 * enable all run on clk; requests are single-cycle strobes.
 */
`timescale 1ns/10ps
`default_nettype none
`include "mmc_consts.svh"
module mmc_config_regs #(
    parameter int ADDR_W = 16
) (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic ce,
    input wire logic sw_rst,
    input wire mmc_pkg::mmc_req_s req,
    input wire logic chan_group_sel,
    input wire logic capture_port_enable,
    output logic [7:0] rdata_r,
    output logic rvalid_r,
    output mmc_pkg::mmc_cfg_s cfg_r,
    output logic read_clear_active_r,
    output logic capture_allowed_r,
    output logic group_mismatch_r
);
    initial begin
        if (ADDR_W != 16) begin
            $error("mmc_config_regs: register port address must be 16 bits");
        end
    end

    logic [7:0] peak_r, peak_nxt;
    logic [7:0] acc_r, acc_nxt;
    logic [7:0] lcy_r, lcy_nxt;
    logic [7:0] cap_r, cap_nxt;
    logic [7:0] lock_r, lock_nxt;
    logic [7:0] rd_mux;
    logic rclr_nxt, cap_ok_nxt, mism_nxt;

    wire logic wr_peak = req.wr && req.addr == `MMC_ADDR_PEAK;
    wire logic wr_acc = req.wr && req.addr == `MMC_ADDR_ACC;
    wire logic wr_lcy = req.wr && req.addr == `MMC_ADDR_LCY;
    wire logic wr_cap = req.wr && req.addr == `MMC_ADDR_CAP;
    wire logic wr_lock = req.wr && req.addr == `MMC_ADDR_LOCK;
    wire logic [1:0] w_racc = req.wdata[`MMC_REACT_ACC_MSB:`MMC_REACT_ACC_LSB];
    wire logic [1:0] w_aacc = req.wdata[`MMC_ACT_ACC_MSB:`MMC_ACT_ACC_LSB];
    wire logic [1:0] w_cont = req.wdata[`MMC_CONT_MSB:`MMC_CONT_LSB];

    // reserved codes are refused: the field keeps its old value
    wire logic [1:0] racc_keep = (w_racc == `MMC_ACC_SIGNED) ? w_racc
        : acc_r[`MMC_REACT_ACC_MSB:`MMC_REACT_ACC_LSB];
    wire logic [1:0] aacc_keep = (w_aacc == `MMC_ACC_SIGNED) ? w_aacc
        : acc_r[`MMC_ACT_ACC_MSB:`MMC_ACT_ACC_LSB];
    wire logic [1:0] cont_keep = (w_cont == `MMC_CONT_WAVE) ? w_cont
        : cap_r[`MMC_CONT_MSB:`MMC_CONT_LSB];

    // bits 5:4 of the accumulation register store what software wrote,
    // relying on software to write back the value it read
    assign peak_nxt = req.wdata & `MMC_WMASK_PEAK;
    assign acc_nxt = (req.wdata & `MMC_WMASK_ACC)
        | {4'h0, racc_keep, aacc_keep};
    assign lcy_nxt = req.wdata
        & `MMC_WMASK_LCY;
    assign cap_nxt = (req.wdata & `MMC_WMASK_CAP)
        | {3'h0, cont_keep, 3'h0};
    // lock is set-only: once the port is locked, only a reset frees it
    assign lock_nxt = {6'h00, lock_r[`MMC_LOCK_BIT] | req.wdata[`MMC_LOCK_BIT],
        req.wdata[`MMC_EXTREF_BIT]};

    assign rd_mux = (req.addr == `MMC_ADDR_PEAK) ? peak_r
        : (req.addr == `MMC_ADDR_ACC) ? acc_r
        : (req.addr == `MMC_ADDR_LCY) ? lcy_r
        : (req.addr == `MMC_ADDR_CAP) ? cap_r
        : (req.addr == `MMC_ADDR_LOCK) ? lock_r : 8'h00;

    // read-clear means nothing while either line-cycle mode runs
    assign rclr_nxt = lcy_r[`MMC_READ_CLR_BIT]
        && !lcy_r[`MMC_LC_REACT_BIT] && !lcy_r[`MMC_LC_ACT_BIT];
    assign cap_ok_nxt = capture_port_enable
        && cap_r[`MMC_CONT_MSB:`MMC_CONT_LSB] == `MMC_CONT_WAVE;
    // the sign monitors only see valid data when the compensation group
    // matches; flagged here so firmware slips show up
    assign mism_nxt = (acc_r[`MMC_REACT_SEL_BIT] != chan_group_sel)
        || (acc_r[`MMC_ACT_SEL_BIT] != chan_group_sel);

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            peak_r <= `MMC_RST_PEAK;
            acc_r <= `MMC_RST_ACC;
            lcy_r <= `MMC_RST_LCY;
            cap_r <= `MMC_RST_CAP;
            lock_r <= `MMC_RST_LOCK;
        end else if (ce && sw_rst) begin
            peak_r <= `MMC_RST_PEAK;
            acc_r <= `MMC_RST_ACC;
            lcy_r <= `MMC_RST_LCY;
            cap_r <= `MMC_RST_CAP;
            lock_r <= `MMC_RST_LOCK;
        end else if (ce) begin
            if (wr_peak) peak_r <= peak_nxt;
            if (wr_acc) acc_r <= acc_nxt;
            if (wr_lcy) lcy_r <= lcy_nxt;
            if (wr_cap) cap_r <= cap_nxt;
            if (wr_lock) lock_r <= lock_nxt;
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            rdata_r <= 8'h00;
            rvalid_r <= 1'b0;
        end else if (ce) begin
            rvalid_r <= req.rd;
            if (req.rd) rdata_r <= rd_mux;
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            read_clear_active_r <= 1'b0;
            capture_allowed_r <= 1'b0;
            group_mismatch_r <= 1'b0;
        end else if (ce) begin
            read_clear_active_r <= rclr_nxt;
            capture_allowed_r <= cap_ok_nxt;
            group_mismatch_r <= mism_nxt;
        end
    end

    // one peak-source bit per current channel pair
    genvar gi;
    generate
        for (gi = 0; gi < 3; gi++) begin : g_peak
            assign cfg_r.peak_src[gi] = peak_r[`MMC_PEAK_LSB + gi];
        end
    endgenerate

    // the sign selects share the accumulation register with its modes
    assign cfg_r.reactive_sign_group_sel =
        acc_r[`MMC_REACT_SEL_BIT];
    assign cfg_r.active_sign_group_sel =
        acc_r[`MMC_ACT_SEL_BIT];
    assign cfg_r.reactive_accum_mode =
        acc_r[`MMC_REACT_ACC_MSB:`MMC_REACT_ACC_LSB];
    assign cfg_r.active_accum_mode = acc_r[`MMC_ACT_ACC_MSB:`MMC_ACT_ACC_LSB];
    assign cfg_r.read_clear_enable = lcy_r[`MMC_READ_CLR_BIT];
    assign cfg_r.voltage_crossing_count_en = lcy_r[`MMC_ZX_CNT_BIT];
    assign cfg_r.reactive_line_cycle_en = lcy_r[`MMC_LC_REACT_BIT];
    assign cfg_r.active_line_cycle_en = lcy_r[`MMC_LC_ACT_BIT];
    assign cfg_r.capture_strobe_polarity = cap_r[`MMC_POL_BIT];
    assign cfg_r.capture_content_sel = cap_r[`MMC_CONT_MSB:`MMC_CONT_LSB];
    assign cfg_r.capture_package_gap = cap_r[`MMC_GAP_BIT];
    assign cfg_r.capture_package_size = cap_r[`MMC_SIZE_BIT];
    assign cfg_r.capture_serial_clock = cap_r[`MMC_HCLK_BIT];
    assign cfg_r.external_reference_en = lock_r[`MMC_EXTREF_BIT];
    assign cfg_r.port_lock = lock_r[`MMC_LOCK_BIT];

    default clocking cb @(posedge clk); endclocking
    default disable iff (!arst_n);

    sequence s_wr(logic [15:0] a);
        ce && !sw_rst && req.wr && req.addr == a;
    endsequence
    sequence s_swrst;
        ce && sw_rst;
    endsequence
    sequence s_rd(logic [15:0] a);
        ce && req.rd && req.addr == a;
    endsequence

    peak_write_a: assert property (
        s_wr(`MMC_ADDR_PEAK) |=> cfg_r.peak_src == $past(req.wdata[4:2]))
        else $error("peak source bits did not take the write");
    sign_sel_a: assert property (
        s_wr(`MMC_ADDR_ACC) |=> {cfg_r.reactive_sign_group_sel,
        cfg_r.active_sign_group_sel} == $past(req.wdata[7:6]))
        else $error("sign group selects did not take the write");
    accum_signed_a: assert property (
        cfg_r.reactive_accum_mode == `MMC_ACC_SIGNED
        && cfg_r.active_accum_mode == `MMC_ACC_SIGNED)
        else $error("accumulation field holds a reserved code");
    acc_spare_a: assert property (
        s_wr(`MMC_ADDR_ACC) |=> acc_r[7:4] == $past(req.wdata[7:4]))
        else $error("accumulation upper bits not stored");
    read_clear_a: assert property (
        ce |=> read_clear_active_r == ($past(lcy_r[6])
        && !$past(lcy_r[1]) && !$past(lcy_r[0])))
        else $error("read-clear qualification wrong");
    line_cycle_a: assert property (
        s_wr(`MMC_ADDR_LCY) ##1 !ce [*2] |-> {lcy_r[3], lcy_r[1:0]}
        == $past({req.wdata[3], req.wdata[1:0]}, 2))
        else $error("line-cycle bits lost or not frozen");
    cap_bits_a: assert property (
        s_wr(`MMC_ADDR_CAP) |=> {cap_r[5], cap_r[2:0]}
        == $past({req.wdata[5], req.wdata[2:0]}))
        else $error("capture config bits did not take the write");
    cap_content_a: assert property (
        capture_allowed_r |-> $past(capture_port_enable)
        && cfg_r.capture_content_sel == `MMC_CONT_WAVE || $past(wr_cap))
        else $error("capture allowed without enable or valid content");
    ext_ref_a: assert property (
        s_wr(`MMC_ADDR_LOCK) |=> cfg_r.external_reference_en
        == $past(req.wdata[0]))
        else $error("external reference enable not stored");
    group_match_a: assert property (
        ce |=> group_mismatch_r == ($past(chan_group_sel)
        != $past(acc_r[7]) || $past(chan_group_sel) != $past(acc_r[6])))
        else $error("group mismatch flag wrong");
    sw_reset_a: assert property (
        s_swrst |=> peak_r == `MMC_RST_PEAK && lcy_r == `MMC_RST_LCY
        && acc_r == `MMC_RST_ACC && cap_r == `MMC_RST_CAP
        && lock_r == `MMC_RST_LOCK)
        else $error("software reset did not restore defaults");
    lock_sticky_a: assert property (
        ce && !sw_rst && cfg_r.port_lock |=> cfg_r.port_lock)
        else $error("port lock dropped without reset");
    read_back_a: assert property (
        ce && req.rd && req.addr == `MMC_ADDR_LCY && !req.wr && !sw_rst
        |=> rvalid_r && rdata_r == $past(lcy_r))
        else $error("read-back of line-cycle register wrong");

    rvalid_pulse_a: assert property (
        ce |=> rvalid_r == $past(req.rd))
        else $error("read valid pulse wrong");

    rdata_hold_a: assert property (
        ce && !req.rd |=> $stable(rdata_r))
        else $error("read data changed without a read");

    state_freeze_a: assert property (
        !ce |=> $stable(peak_r) && $stable(acc_r) && $stable(lcy_r)
        && $stable(cap_r) && $stable(lock_r) && $stable(rvalid_r))
        else $error("state moved while clock enable was low");

    write_only_a: assert property (
        ce && !sw_rst && !req.wr |=> $stable(peak_r) && $stable(acc_r)
        && $stable(lcy_r) && $stable(cap_r) && $stable(lock_r))
        else $error("register changed without a write");

    peak_read_a: assert property (
        s_rd(`MMC_ADDR_PEAK) |=> rdata_r == $past(peak_r))
        else $error("read-back of peak source register wrong");

    acc_read_a: assert property (
        s_rd(`MMC_ADDR_ACC) |=> rdata_r == $past(acc_r))
        else $error("read-back of accumulation register wrong");

    cap_read_a: assert property (
        s_rd(`MMC_ADDR_CAP) |=> rdata_r == $past(cap_r))
        else $error("read-back of capture register wrong");

    lock_read_a: assert property (
        s_rd(`MMC_ADDR_LOCK) |=> rdata_r == $past(lock_r))
        else $error("read-back of lock register wrong");

    unmapped_read_a: assert property (
        ce && req.rd && !(req.addr inside {`MMC_ADDR_PEAK, `MMC_ADDR_ACC,
        `MMC_ADDR_LCY, `MMC_ADDR_CAP, `MMC_ADDR_LOCK}) |=> rdata_r == 8'h00)
        else $error("unmapped read did not return zero");

    content_refused_a: assert property (
        s_wr(`MMC_ADDR_CAP) ##0 req.wdata[4:3] != `MMC_CONT_WAVE
        |=> $stable(cfg_r.capture_content_sel))
        else $error("reserved capture content code was stored");

    content_taken_a: assert property (
        s_wr(`MMC_ADDR_CAP) ##0 req.wdata[4:3] == `MMC_CONT_WAVE
        |=> cfg_r.capture_content_sel == `MMC_CONT_WAVE)
        else $error("waveform capture content code not stored");

    lock_set_a: assert property (
        s_wr(`MMC_ADDR_LOCK) ##0 req.wdata[1] |=> cfg_r.port_lock)
        else $error("port lock not set by write");

    capture_off_a: assert property (
        ce && !capture_port_enable |=> !capture_allowed_r)
        else $error("capture allowed while port enable low");

    reserved_zero_a: assert property (
        peak_r[7:5] == 3'h0 && peak_r[1:0] == 2'h0 && lcy_r[7] == 1'h0
        && lcy_r[5:4] == 2'h0 && lcy_r[2] == 1'h0 && cap_r[7:6] == 2'h0
        && lock_r[7:2] == 6'h00)
        else $error("reserved register bit holds a one");
endmodule : mmc_config_regs
`default_nettype wire

// ==== logic/mmc_consts.svh ====
/*
 * Constants of the metering mode configuration register bank: addresses,
 * field positions, reset values and field codes.
 * Assumes a 16-bit register address space on the serial register port.
 */
`ifndef MMC_CONSTS_SVH
`define MMC_CONSTS_SVH
`define MMC_ADDR_PEAK 16'hE700
`define MMC_ADDR_ACC 16'hE701
`define MMC_ADDR_LCY 16'hE702
`define MMC_ADDR_CAP 16'hE706
`define MMC_ADDR_LOCK 16'hEC01
`define MMC_RST_PEAK 8'h1C
`define MMC_RST_ACC 8'h00
`define MMC_RST_LCY 8'h40
`define MMC_RST_CAP 8'h00
`define MMC_RST_LOCK 8'h00
`define MMC_WMASK_PEAK 8'h1C
`define MMC_WMASK_ACC 8'hF0
`define MMC_WMASK_LCY 8'h4B
`define MMC_WMASK_CAP 8'h27
`define MMC_PEAK_LSB 2
`define MMC_REACT_SEL_BIT 7
`define MMC_ACT_SEL_BIT 6
`define MMC_REACT_ACC_MSB 3
`define MMC_REACT_ACC_LSB 2
`define MMC_ACT_ACC_MSB 1
`define MMC_ACT_ACC_LSB 0
`define MMC_ACC_SIGNED 2'h0
`define MMC_READ_CLR_BIT 6
`define MMC_ZX_CNT_BIT 3
`define MMC_LC_REACT_BIT 1
`define MMC_LC_ACT_BIT 0
`define MMC_POL_BIT 5
`define MMC_CONT_MSB 4
`define MMC_CONT_LSB 3
`define MMC_CONT_WAVE 2'h1
`define MMC_GAP_BIT 2
`define MMC_SIZE_BIT 1
`define MMC_HCLK_BIT 0
`define MMC_GAP_CYCLES 7
`define MMC_LOCK_BIT 1
`define MMC_EXTREF_BIT 0
`endif

// ==== logic/mmc_pkg.sv ====
/*
 * Types of the metering mode configuration register bank.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
`default_nettype none
package mmc_pkg;
    typedef struct packed {
        logic [15:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } mmc_req_s;

    typedef struct packed {
        logic [2:0] peak_src;
        logic reactive_sign_group_sel;
        logic active_sign_group_sel;
        logic [1:0] reactive_accum_mode;
        logic [1:0] active_accum_mode;
        logic read_clear_enable;
        logic voltage_crossing_count_en;
        logic reactive_line_cycle_en;
        logic active_line_cycle_en;
        logic capture_strobe_polarity;
        logic [1:0] capture_content_sel;
        logic capture_package_gap;
        logic capture_package_size;
        logic capture_serial_clock;
        logic external_reference_en;
        logic port_lock;
    } mmc_cfg_s;
endpackage : mmc_pkg
`default_nettype wire

// ==== testbench/mmc_host_model.sv ====
/*
 * Host software model: issues register writes and reads on the
 * serial register port of the mode configuration bank.
 * Assumes one clock; requests change on the falling edge only.
 */
`timescale 1ns/10ps
`default_nettype none
module mmc_host_model (
    input wire logic clk,
    output var mmc_pkg::mmc_req_s req,
    input wire logic [7:0] rdata_r,
    input wire logic rvalid_r
);
    initial req = '0;

    // one-cycle strobe, taken at the rising edge in between
    task automatic write_reg(input logic [15:0] a, input logic [7:0] d);
        @(negedge clk);
        req = '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(negedge clk);
        req = '0;
    endtask : write_reg

    // returns {valid, data} at the falling edge right after the edge that takes the request
    task automatic read_reg(input logic [15:0] a, output logic [8:0] d);
        @(negedge clk);
        req = '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(negedge clk);
        d = {rvalid_r, rdata_r};
        req = '0;
    endtask : read_reg
endmodule : mmc_host_model
`default_nettype wire

// ==== testbench/tb.sv ====
/*
 * Self-checking bench of the mode configuration register bank.
 * Assumes the host model drives the register port; 25 MHz clock.
 */
`timescale 1ns/10ps
`default_nettype none
`include "mmc_consts.svh"
module tb;
    typedef struct packed {
        logic [15:0] a;
        logic [7:0] w;
        logic [7:0] e;
    } mmc_row_s;
    logic clk = 1'b0;
    logic arst_n = 1'b0;
    logic ce = 1'b1;
    logic sw_rst = 1'b0;
    logic chan_group_sel = 1'b0;
    logic capture_port_enable = 1'b0;
    mmc_pkg::mmc_req_s req;
    logic [7:0] rdata_r;
    logic rvalid_r;
    mmc_pkg::mmc_cfg_s cfg_r;
    logic rca;
    logic cap_ok;
    logic grp_mis;
    logic [8:0] rd_v;
    int err_total = 0;
    int comparisons = 0;
    int cycles = 0;
    // reserved codes keep the old field; lock bit is set-only
    mmc_row_s rows [16] = '{
        '{16'hE700, 8'hFF, 8'h1C}, '{16'hE700, 8'h00, 8'h00},
        '{16'hE700, 8'h14, 8'h14}, '{16'hE701, 8'hC0, 8'hC0},
        '{16'hE701, 8'h0F, 8'h00}, '{16'hE702, 8'hFF, 8'h4B},
        '{16'hE702, 8'h00, 8'h00}, '{16'hE702, 8'h40, 8'h40},
        '{16'hE706, 8'h21, 8'h21}, '{16'hE706, 8'h2F, 8'h2F},
        '{16'hE706, 8'hFF, 8'h2F}, '{16'hE706, 8'h00, 8'h08},
        '{16'hEC01, 8'h01, 8'h01}, '{16'hEC01, 8'h02, 8'h02},
        '{16'hEC01, 8'h00, 8'h02}, '{16'hE703, 8'hFF, 8'h00}};
    logic [15:0] def_a [5] = '{16'hE700, 16'hE701, 16'hE702, 16'hE706,
        16'hEC01};
    logic [7:0] def_e [5] = '{8'h1C, 8'h00, 8'h40, 8'h00, 8'h00};

    always #20 clk = ~clk;

    mmc_config_regs #(.ADDR_W(16)) dut (
        .clk(clk), .arst_n(arst_n), .ce(ce), .sw_rst(sw_rst), .req(req),
        .chan_group_sel(chan_group_sel),
        .capture_port_enable(capture_port_enable),
        .rdata_r(rdata_r), .rvalid_r(rvalid_r), .cfg_r(cfg_r),
        .read_clear_active_r(rca), .capture_allowed_r(cap_ok),
        .group_mismatch_r(grp_mis)
    );

    mmc_host_model host (
        .clk(clk), .req(req), .rdata_r(rdata_r), .rvalid_r(rvalid_r)
    );

    task automatic chk(input logic [8:0] seen, input logic [8:0] exp);
        comparisons++;
        if (seen !== exp) begin
            err_total++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : chk

    task automatic final_report();
        $display("errors %0d comparisons %0d", err_total, comparisons);
        if (err_total == 0 && comparisons > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : final_report

    task automatic rd_chk(input logic [15:0] a, input logic [7:0] e);
        host.read_reg(a, rd_v);
        chk(rd_v, {1'b1, e});
    endtask : rd_chk

    // the whole run needs well under a thousand cycles
    always @(posedge clk) begin
        cycles++;
        if (cycles == 3000) begin
            err_total++;
            final_report();
        end
    end

    initial begin
        repeat (2) @(negedge clk);
        arst_n = 1'b1;
        @(negedge clk);
        chk({8'h00, rca}, 9'h001);
        chk({6'h00, cfg_r.peak_src}, 9'h007);
        for (int i = 0; i < 5; i++) begin
            rd_chk(def_a[i], def_e[i]);
        end
        for (int i = 0; i < 16; i++) begin
            host.write_reg(rows[i].a, rows[i].w);
            host.read_reg(rows[i].a, rd_v);
            chk(rd_v, {1'b1, rows[i].e});
        end
        // line-cycle mode masks read-clear even with the enable left set
        host.write_reg(`MMC_ADDR_LCY, 8'h4B);
        @(negedge clk);
        chk({8'h00, rca}, 9'h000);
        chk({6'h00, cfg_r.voltage_crossing_count_en,
            cfg_r.reactive_line_cycle_en,
            cfg_r.active_line_cycle_en}, 9'h007);
        host.write_reg(`MMC_ADDR_LCY, 8'h40);
        @(negedge clk);
        chk({8'h00, rca}, 9'h001);
        chan_group_sel = 1'b1;
        host.write_reg(`MMC_ADDR_ACC, 8'hC0);
        @(negedge clk);
        chk({8'h00, grp_mis}, 9'h000);
        chk({7'h00, cfg_r.reactive_sign_group_sel,
            cfg_r.active_sign_group_sel}, 9'h003);
        chan_group_sel = 1'b0;
        @(negedge clk);
        chk({8'h00, grp_mis}, 9'h001);
        host.write_reg(`MMC_ADDR_CAP, 8'h2F);
        capture_port_enable = 1'b1;
        @(negedge clk);
        chk({8'h00, cap_ok}, 9'h001);
        chk({5'h00, cfg_r.capture_strobe_polarity, cfg_r.capture_package_gap,
            cfg_r.capture_package_size, cfg_r.capture_serial_clock},
            9'h00F);
        capture_port_enable = 1'b0;
        @(negedge clk);
        chk({8'h00, cap_ok}, 9'h000);
        // a line-cycle write followed by two frozen cycles must survive
        host.write_reg(`MMC_ADDR_LCY, 8'h49);
        // frozen clock enable must drop the write
        ce = 1'b0;
        host.write_reg(`MMC_ADDR_PEAK, 8'h00);
        ce = 1'b1;
        chk({6'h00, cfg_r.voltage_crossing_count_en,
            cfg_r.reactive_line_cycle_en,
            cfg_r.active_line_cycle_en}, 9'h005);
        rd_chk(`MMC_ADDR_PEAK, 8'h14);
        host.write_reg(`MMC_ADDR_LOCK, 8'h03);
        chk({8'h00, cfg_r.external_reference_en}, 9'h001);
        sw_rst = 1'b1;
        @(negedge clk);
        sw_rst = 1'b0;
        rd_chk(`MMC_ADDR_LOCK, 8'h00);
        rd_chk(`MMC_ADDR_CAP, 8'h00);
        rd_chk(`MMC_ADDR_PEAK, 8'h1C);
        // second asynchronous reset in mid-run
        host.write_reg(`MMC_ADDR_LCY, 8'h0B);
        arst_n = 1'b0;
        repeat (2) @(negedge clk);
        arst_n = 1'b1;
        rd_chk(`MMC_ADDR_LCY, 8'h40);
        final_report();
    end
endmodule : tb
`default_nettype wire
